/* verilog/iwd_decoder.v */
/*
 * Instruction word decoder: fields, two-word joining, extra cycles as no-ops.
 * Assumes fetch offers one word a cycle with its follower and condition.
 */
// Notes on behaviour
// RL1: Single word is 24 bits; leading 8-bit opcode, rest operand fields.
// RL2: Only three instruction types take two words; others take one.
// RL3: Two-word instruction spans 48 bits; second word's upper 8 bits zero.
// RL4: An orphan second word executes as a no-operation.
// RL5: Plain single-word instructions take one cycle.
// RL6: Taken condition or PC change costs two cycles, extra one a no-op.
// RL7: Branches, indirect jumps, table accesses and returns take two or three.
// RL8: Taken skip costs two cycles, or three over a two-word instruction.
// RL9: Every two-word instruction takes exactly two cycles.
// RL10: Three-operand form gives base, modified source and modified destination.
// RL11: File form gives file address and destination file or register zero.
// RL12: Bit form gives register and bit from immediate or base register.
// RL13: Literal move gives immediate and target register to load.
// RL14: Literal arithmetic uses base and immediate; destination only if different.
// RL15: Control form gives program address or table access mode.
// RL16: Working register selectors address sixteen registers, zero to fifteen.
// RL17: Flags updated are carry, digit carry, negative, overflow, sticky zero.
// RL18: A flag after a two-word first word takes the next as operand.
`timescale 1ns/10ps
`default_nettype none
`include "iwd_defines.vh"

module iwd_decoder (
    input  wire                    clk_in,
    input  wire                    nrst_in,
    input  wire [`IWD_WORD_W-1:0]  word_in,
    input  wire                    word_valid_in,
    input  wire [`IWD_WORD_W-1:0]  next_word_in,
    input  wire                    cond_true_in,
    output wire                    word_ready_out,
    output reg                     dec_valid_out,
    output reg                     nop_out,
    output reg  [7:0]              opcode_out,
    output reg  [`IWD_CLS_W-1:0]   class_out,
    output reg                     two_word_out,
    output reg  [1:0]              cycles_out,
    output reg  [4:0]              flag_mask_out,
    output reg  [3:0]              base_reg_sel_out,
    output reg  [3:0]              src_reg_sel_out,
    output reg  [1:0]              src_mode_out,
    output reg  [3:0]              dst_reg_sel_out,
    output reg  [1:0]              dst_mode_out,
    output reg  [12:0]             file_addr_out,
    output reg                     dst_is_work_reg_zero_out,
    output reg  [3:0]              bit_pos_out,
    output reg                     bit_from_reg_out,
    output reg  [15:0]             literal_out,
    output reg  [22:0]             prog_addr_out,
    output reg  [1:0]              table_mode_out,
    output wire                    operand_pending_out
);

    // ------------------------------------------------------------------
    // Classification of current and following word
    // ------------------------------------------------------------------
    wire [`IWD_CLS_W-1:0] cls_w;
    wire [`IWD_CLS_W-1:0] next_cls_w;
    wire [7:0]            op_w;
    wire [15:0]           opnd_w;

    // RL1 opcode split
    assign op_w   = word_in[`IWD_OP_HI:`IWD_OP_LO];
    assign opnd_w = word_in[`IWD_F_LIT16];

    iwd_op_class u_cls_cur (
        .op_in      (op_w),
        .class_out  (cls_w)
    );

    iwd_op_class u_cls_next (
        .op_in      (next_word_in[`IWD_OP_HI:`IWD_OP_LO]),
        .class_out  (next_cls_w)
    );

    // ------------------------------------------------------------------
    // Cycle count of a single-word instruction
    // ------------------------------------------------------------------
    reg [1:0] cyc_d;

    always @* begin
        cyc_d = `IWD_CYC_1;
        if (cls_w[`IWD_C_RET]) begin
            // RL7 returns three
            cyc_d = `IWD_CYC_3;
        end else if (cls_w[`IWD_C_BRA] || cls_w[`IWD_C_IND] || cls_w[`IWD_C_TBL]) begin
            // RL7 fixed two
            cyc_d = `IWD_CYC_2;
        end else if (cls_w[`IWD_C_CBR] && cond_true_in) begin
            // RL6 taken condition
            cyc_d = `IWD_CYC_2;
        end else if (cls_w[`IWD_C_SKIP] && cond_true_in) begin
            // RL8 skip length
            cyc_d = next_cls_w[`IWD_C_TWO] ? `IWD_CYC_3 : `IWD_CYC_2;
        end
    end

    // ------------------------------------------------------------------
    // Status flag mask per class
    // ------------------------------------------------------------------
    reg [4:0] flg_d;

    always @* begin
        flg_d = `IWD_FLG_NONE;
        // RL17 flag groups
        if (cls_w[`IWD_C_AR3] || cls_w[`IWD_C_ARL] || cls_w[`IWD_C_FILE]) begin
            flg_d = `IWD_FLG_ALL;
        end else if (cls_w[`IWD_C_LOG3]) begin
            flg_d = `IWD_FLG_NZ;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer: decode, second-word operand, squash
    // ------------------------------------------------------------------
    localparam [2:0] ST_DEC  = `IWD_ST_DEC;
    localparam [2:0] ST_OPND = `IWD_ST_OPND;
    localparam [2:0] ST_SQ   = `IWD_ST_SQ;

    reg [2:0] state_q;
    reg [1:0] squash_q;

    // Every word is consumed in its cycle; no back-pressure needed
    assign word_ready_out      = 1'b1;
    assign operand_pending_out = state_q[1];

    // State, squash count and outputs
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            state_q          <= ST_DEC;
            squash_q         <= 2'h0;
            dec_valid_out    <= 1'b0;
            nop_out          <= 1'b0;
            opcode_out       <= `IWD_ZERO_OP;
            class_out        <= {`IWD_CLS_W{1'b0}};
            two_word_out     <= 1'b0;
            cycles_out       <= `IWD_CYC_1;
            flag_mask_out    <= `IWD_FLG_NONE;
            base_reg_sel_out <= 4'h0;
            src_reg_sel_out  <= 4'h0;
            src_mode_out     <= 2'h0;
            dst_reg_sel_out  <= 4'h0;
            dst_mode_out     <= 2'h0;
            file_addr_out    <= 13'h0000;
            dst_is_work_reg_zero_out  <= 1'b0;
            bit_pos_out      <= 4'h0;
            bit_from_reg_out <= 1'b0;
            literal_out      <= 16'h0000;
            prog_addr_out    <= 23'h000000;
            table_mode_out   <= 2'h0;
        end else begin
            dec_valid_out <= 1'b0;
            nop_out       <= 1'b0;
            case (state_q)
                ST_DEC: begin
                    if (word_valid_in) begin
                        opcode_out       <= op_w;
                        class_out        <= cls_w;
                        flag_mask_out    <= flg_d;
                        // RL10 RL16 three-operand fields
                        base_reg_sel_out <= word_in[`IWD_F_BASE];
                        src_reg_sel_out  <= word_in[`IWD_F_SRC];
                        src_mode_out     <= word_in[`IWD_F_SMODE];
                        dst_reg_sel_out  <= word_in[`IWD_F_DST];
                        dst_mode_out     <= word_in[`IWD_F_DMODE];
                        // RL11 file operands
                        file_addr_out    <= word_in[`IWD_F_FADDR];
                        dst_is_work_reg_zero_out  <= word_in[`IWD_F_FWREG];
                        // RL15 table access mode
                        table_mode_out   <= word_in[`IWD_F_TMODE];
                        bit_pos_out      <= 4'h0;
                        bit_from_reg_out <= 1'b0;
                        literal_out      <= opnd_w;
                        prog_addr_out    <= {7'h00, opnd_w};
                        if (cls_w[`IWD_C_BIT] || cls_w[`IWD_C_SKIP]) begin
                            // RL12 bit from literal or base
                            bit_from_reg_out <= word_in[`IWD_F_BITIND];
                            bit_pos_out      <= word_in[`IWD_F_BITIND] ? 4'h0
                                                : word_in[`IWD_F_BITPOS];
                            base_reg_sel_out <= word_in[`IWD_F_BITBASE];
                        end
                        if (cls_w[`IWD_C_MOVL]) begin
                            // RL13 literal into target
                            literal_out <= {4'h0, word_in[`IWD_F_LIT12]};
                        end
                        if (cls_w[`IWD_C_ARL]) begin
                            // RL14 destination defaults to base
                            literal_out <= {11'h000, word_in[`IWD_F_LIT5]};
                            if (word_in[`IWD_F_SAMEDST]) begin
                                dst_reg_sel_out <= word_in[`IWD_F_BASE];
                                dst_mode_out    <= 2'h0;
                            end
                        end
                        if (cls_w[`IWD_C_TWO]) begin
                            // RL2 RL18 hold for operand word
                            state_q <= ST_OPND;
                        end else begin
                            // RL4 RL5 single-word issue; a no-op decodes nothing
                            dec_valid_out <= !cls_w[`IWD_C_NOP];
                            nop_out       <= cls_w[`IWD_C_NOP];
                            two_word_out  <= 1'b0;
                            cycles_out    <= cyc_d;
                            if (cyc_d != `IWD_CYC_1) begin
                                // RL6 extra cycles squashed
                                squash_q <= cyc_d - `IWD_CYC_1;
                                state_q  <= ST_SQ;
                            end
                        end
                    end
                end
                ST_OPND: begin
                    if (word_valid_in) begin
                        // RL3 RL9 join 48 bits, two cycles
                        dec_valid_out <= 1'b1;
                        two_word_out  <= 1'b1;
                        cycles_out    <= `IWD_CYC_2;
                        prog_addr_out <= {word_in[`IWD_F_AHI], prog_addr_out[15:0]};
                        literal_out   <= opnd_w;
                        state_q       <= ST_DEC;
                    end
                end
                ST_SQ: begin
                    if (word_valid_in) begin
                        // RL8 skipped words run as no-op
                        nop_out  <= 1'b1;
                        squash_q <= squash_q - 2'h1;
                        if (squash_q == 2'h1) begin
                            state_q <= ST_DEC;
                        end
                    end
                end
                default: begin
                    state_q <= ST_DEC;
                end
            endcase
        end
    end

endmodule // iwd_decoder

`default_nettype wire

/* verilog/iwd_defines.vh */
/*
 * Decoder constants: word layout, opcodes, fields, classes, cycles, states.
 * Assumes inclusion by bare name from the decoder files only.
 */
`ifndef IWD_DEFINES_VH
`define IWD_DEFINES_VH

// ----------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------
`define IWD_WORD_W      24
`define IWD_OP_HI       23
`define IWD_OP_LO       16
`define IWD_ZERO_OP     8'h00

// ----------------------------------------------------------------------
// Opcode map (first word)
// ----------------------------------------------------------------------
`define IWD_OP_IND      8'h01
`define IWD_OP_CALL     8'h02
`define IWD_OP_JUMP     8'h04
`define IWD_OP_RET      8'h06
`define IWD_OP_IRET     8'h07
`define IWD_OP_MOVD     8'h08
`define IWD_OP_MOVL_LO  8'h20
`define IWD_OP_MOVL_HI  8'h2F
`define IWD_OP_CBR_LO   8'h30
`define IWD_OP_CBR_HI   8'h36
`define IWD_OP_BRA      8'h37
`define IWD_OP_AR3_LO   8'h40
`define IWD_OP_AR3_HI   8'h5F
`define IWD_OP_LOG3_LO  8'h60
`define IWD_OP_LOG3_HI  8'h6F
`define IWD_OP_BIT_LO   8'hA0
`define IWD_OP_BIT_HI   8'hA5
`define IWD_OP_SKIP_LO  8'hA6
`define IWD_OP_SKIP_HI  8'hA7
`define IWD_OP_ARL_LO   8'hB0
`define IWD_OP_ARL_HI   8'hB3
`define IWD_OP_FILE_LO  8'hB4
`define IWD_OP_FILE_HI  8'hB7
`define IWD_OP_TBL_LO   8'hBA
`define IWD_OP_TBL_HI   8'hBB

// ----------------------------------------------------------------------
// Operand fields
// ----------------------------------------------------------------------
`define IWD_F_BASE      15:12
`define IWD_F_SMODE     11:10
`define IWD_F_SRC       9:6
`define IWD_F_DMODE     5:4
`define IWD_F_DST       3:0
`define IWD_F_FADDR     12:0
`define IWD_F_FWREG     13
`define IWD_F_BITPOS    15:12
`define IWD_F_BITIND    11
`define IWD_F_BITBASE   10:7
`define IWD_F_LIT5      11:7
`define IWD_F_SAMEDST   6
`define IWD_F_LIT12     15:4
`define IWD_F_LIT16     15:0
`define IWD_F_TMODE     15:14
`define IWD_F_AHI       6:0

// ----------------------------------------------------------------------
// Class vector bits
// ----------------------------------------------------------------------
`define IWD_CLS_W       14
`define IWD_C_NOP       0
`define IWD_C_TWO       1
`define IWD_C_IND       2
`define IWD_C_RET       3
`define IWD_C_BRA       4
`define IWD_C_CBR       5
`define IWD_C_MOVL      6
`define IWD_C_AR3       7
`define IWD_C_LOG3      8
`define IWD_C_ARL       9
`define IWD_C_FILE      10
`define IWD_C_BIT       11
`define IWD_C_SKIP      12
`define IWD_C_TBL       13

// ----------------------------------------------------------------------
// Status flag mask bits {C, DC, N, OV, Z}
// ----------------------------------------------------------------------
`define IWD_FLG_ALL     5'h1F
`define IWD_FLG_NZ      5'h05
`define IWD_FLG_NONE    5'h00

// ----------------------------------------------------------------------
// Cycle counts and states
// ----------------------------------------------------------------------
`define IWD_CYC_1       2'h1
`define IWD_CYC_2       2'h2
`define IWD_CYC_3       2'h3
`define IWD_ST_DEC      3'h1
`define IWD_ST_OPND     3'h2
`define IWD_ST_SQ       3'h4

`endif

/* verilog/iwd_op_class.v */
/*
 * Opcode classifier: leading 8-bit field to a one-hot class vector.
 * Assumes the caller registers what it needs.
 */
`timescale 1ns/10ps
`default_nettype none
`include "iwd_defines.vh"

module iwd_op_class (
    input  wire [7:0]              op_in,
    output reg  [`IWD_CLS_W-1:0]   class_out
);

    // Range decode of the opcode into one class
    always @* begin
        class_out = {`IWD_CLS_W{1'b0}};
        if (op_in == `IWD_OP_CALL || op_in == `IWD_OP_JUMP || op_in == `IWD_OP_MOVD) begin
            class_out[`IWD_C_TWO] = 1'b1;
        end else if (op_in == `IWD_OP_IND) begin
            class_out[`IWD_C_IND] = 1'b1;
        end else if (op_in == `IWD_OP_RET || op_in == `IWD_OP_IRET) begin
            class_out[`IWD_C_RET] = 1'b1;
        end else if (op_in == `IWD_OP_BRA) begin
            class_out[`IWD_C_BRA] = 1'b1;
        end else if (op_in >= `IWD_OP_CBR_LO && op_in <= `IWD_OP_CBR_HI) begin
            class_out[`IWD_C_CBR] = 1'b1;
        end else if (op_in >= `IWD_OP_MOVL_LO && op_in <= `IWD_OP_MOVL_HI) begin
            class_out[`IWD_C_MOVL] = 1'b1;
        end else if (op_in >= `IWD_OP_AR3_LO && op_in <= `IWD_OP_AR3_HI) begin
            class_out[`IWD_C_AR3] = 1'b1;
        end else if (op_in >= `IWD_OP_LOG3_LO && op_in <= `IWD_OP_LOG3_HI) begin
            class_out[`IWD_C_LOG3] = 1'b1;
        end else if (op_in >= `IWD_OP_BIT_LO && op_in <= `IWD_OP_BIT_HI) begin
            class_out[`IWD_C_BIT] = 1'b1;
        end else if (op_in >= `IWD_OP_SKIP_LO && op_in <= `IWD_OP_SKIP_HI) begin
            class_out[`IWD_C_SKIP] = 1'b1;
        end else if (op_in >= `IWD_OP_ARL_LO && op_in <= `IWD_OP_ARL_HI) begin
            class_out[`IWD_C_ARL] = 1'b1;
        end else if (op_in >= `IWD_OP_FILE_LO && op_in <= `IWD_OP_FILE_HI) begin
            class_out[`IWD_C_FILE] = 1'b1;
        end else if (op_in >= `IWD_OP_TBL_LO && op_in <= `IWD_OP_TBL_HI) begin
            class_out[`IWD_C_TBL] = 1'b1;
        end else begin
            // Zero opcode and unused codes run as no-operation
            class_out[`IWD_C_NOP] = 1'b1;
        end
    end

endmodule // iwd_op_class

`default_nettype wire

/* bench/iwd_decoder_assertions.sv */
/*
 * Decoder checker: pulses, cycle counts and fields at the top ports.
 * Assumes a bind from the bench top onto iwd_decoder.
 */
`timescale 1ns/10ps
`default_nettype none
module iwd_decoder_checker (
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic [23:0] word_in,
    input wire logic        word_valid_in,
    input wire logic [23:0] next_word_in,
    input wire logic        cond_true_in,
    input wire logic        word_ready_out,
    input wire logic        dec_valid_out,
    input wire logic        nop_out,
    input wire logic [7:0]  opcode_out,
    input wire logic        two_word_out,
    input wire logic [1:0]  cycles_out,
    input wire logic [4:0]  flag_mask_out,
    input wire logic        operand_pending_out
);
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    wire [7:0] op = word_in[23:16];
    wire take = word_valid_in && !operand_pending_out;
    wire two_op = op inside {8'h02, 8'h04, 8'h08};
    wire two_next = next_word_in[23:16] inside {8'h02, 8'h04, 8'h08};

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    chk_ready_always: assert property (word_ready_out)
        else $error("word_ready_out low");
    chk_pulse_excl: assert property (!(dec_valid_out && nop_out))
        else $error("decode with no-op");
    chk_answer_lat: assert property (take && !two_op |=> dec_valid_out || nop_out)
        else $error("no answer to taken word");
    chk_no_spont: assert property (!word_valid_in |=> !dec_valid_out && !nop_out)
        else $error("pulse without word");
    chk_pend_second: assert property (operand_pending_out && word_valid_in |=>
        dec_valid_out && two_word_out && cycles_out == 2'h2 && !operand_pending_out)
        else $error("second word not joined");
    chk_pend_cause: assert property ($rose(operand_pending_out) |-> $past(take && two_op))
        else $error("pending without two-word opcode");
    chk_orphan_nop: assert property (take && op == 8'h00 |=> nop_out && !dec_valid_out)
        else $error("zero opcode not no-op");
    chk_opcode_field: assert property (take ##1 dec_valid_out |->
        opcode_out == $past(word_in[23:16]))
        else $error("opcode field wrong");
    chk_arith_cyc: assert property (take && op inside {[8'h40:8'h5F]} |=>
        !dec_valid_out || (cycles_out == 2'h1 && flag_mask_out == 5'h1F))
        else $error("arith cycles or flags");
    chk_logic_flags: assert property (take && op inside {[8'h60:8'h6F]} |=>
        !dec_valid_out || (cycles_out == 2'h1 && flag_mask_out == 5'h05))
        else $error("logic cycles or flags");
    chk_skip_long: assert property (take && op inside {8'hA6, 8'hA7} && cond_true_in
        && two_next |=> !dec_valid_out || cycles_out == 2'h3)
        else $error("long skip not three cycles");
endmodule // iwd_decoder_checker
`default_nettype wire

/* bench/iwd_fetch_model.sv */
/*
 * Fetch model: one queued word a cycle with follower and condition.
 * Assumes the bench pushes {cond, word} entries between clock edges.
 */
`timescale 1ns/10ps
`default_nettype none
module iwd_fetch_model (
    input  wire logic        clk_in,
    input  wire logic        stall_in,
    output var  logic [23:0] word_out,
    output var  logic        valid_out,
    output var  logic [23:0] next_out,
    output var  logic        cond_out
);
    logic [24:0] q[$];

    // Idle values at time zero
    initial begin
        word_out = 24'h000000;
        valid_out = 1'b0;
        next_out = 24'h000000;
        cond_out = 1'b0;
    end

    // Queue {cond, word}
    task automatic push(input logic [24:0] e);
        q.push_back(e);
    endtask

    // One word a cycle; idle lines toggle against stale data
    always @(posedge clk_in) begin
        if (q.size() > 0 && !stall_in) begin
            valid_out <= 1'b1;
            {cond_out, word_out} <= q[0];
            next_out <= (q.size() > 1) ? q[1][23:0] : ~q[0][23:0];
            q.pop_front();
        end else begin
            valid_out <= 1'b0;
            word_out <= ~word_out;
            next_out <= ~next_out;
            cond_out <= ~cond_out;
        end
    end
endmodule // iwd_fetch_model
`default_nettype wire

/* bench/iwd_decoder_tb.sv */
/*
 * Bench for iwd_decoder: directed and random words against a model.
 * Assumes the fetch model and checker files are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
module iwd_decoder_tb;
    logic clk_in = 1'b0, nrst_in = 1'b0, stall = 1'b0, rnd_on = 1'b0;
    integer seed = 32'h1E5C, miscompares = 0, checks = 0, sq = 0, e_k = 0, e_c = 0;
    logic pend = 1'b0, e_on = 1'b0, e_dec = 1'b0, e_nop = 1'b0;
    logic [23:0] w1, e_w, e_w2;
    wire [23:0] word_w, next_w;
    wire valid_w, cond_w, ready_w, dec_v, nop_v, two_w, pend_w, work_reg_zero_w, bfr_w;
    wire [7:0] op_o;
    wire [13:0] cls_o;
    wire [1:0] cyc_o, smode_o, dmode_o, tmode_o;
    wire [4:0] flg_o;
    wire [3:0] base_o, src_o, dst_o, bpos_o;
    wire [12:0] faddr_o;
    wire [15:0] lit_o;
    wire [22:0] paddr_o;
    logic [24:0] dir [41] = '{25'h0409A5B, 25'h06C3C21, 25'h02F8765, 25'h0B052C3,
        25'h0B15203, 25'h0B52ABC, 25'h0A0A123, 25'h0A1F8C0, 25'h0BAC000, 25'h1300010,
        25'h0401111, 25'h0360020, 25'h0060000, 25'h0550000, 25'h0400000, 25'h1A65000,
        25'h0041234, 25'h0000056, 25'h1A71000, 25'h0402222, 25'h0A60000, 25'h0041234,
        25'h000007F, 25'h002ABCD, 25'h0001357, 25'h0080002, 25'h0008001, 25'h000ABCD,
        25'h0FF0000, 25'h0010000, 25'h0FF0000, 25'h0FF0000, 25'h0070000, 25'h0FF0000,
        25'h0FF0000, 25'h0370000, 25'h0FF0000, 25'h0FF0000, 25'h0BB4000, 25'h0FF0000,
        25'h0FF0000};
    logic [7:0] ops [27] = '{8'h40, 8'h5F, 8'h60, 8'h6F, 8'h20, 8'h2F, 8'h30, 8'h36,
        8'hA0, 8'hA5, 8'hA6, 8'hA7, 8'hB0, 8'hB3, 8'hB4, 8'hB7, 8'hBA, 8'hBB, 8'h02,
        8'h04, 8'h08, 8'h06, 8'h07, 8'h01, 8'h37, 8'h00, 8'hFF};

    iwd_fetch_model u_iwd_fetch_model (.clk_in(clk_in), .stall_in(stall),
        .word_out(word_w), .valid_out(valid_w), .next_out(next_w), .cond_out(cond_w));
    iwd_decoder u_iwd_decoder (.clk_in(clk_in), .nrst_in(nrst_in), .word_in(word_w),
        .word_valid_in(valid_w), .next_word_in(next_w), .cond_true_in(cond_w),
        .word_ready_out(ready_w), .dec_valid_out(dec_v), .nop_out(nop_v),
        .opcode_out(op_o), .class_out(cls_o), .two_word_out(two_w), .cycles_out(cyc_o),
        .flag_mask_out(flg_o), .base_reg_sel_out(base_o), .src_reg_sel_out(src_o),
        .src_mode_out(smode_o), .dst_reg_sel_out(dst_o), .dst_mode_out(dmode_o),
        .file_addr_out(faddr_o), .dst_is_work_reg_zero_out(work_reg_zero_w), .bit_pos_out(bpos_o),
        .bit_from_reg_out(bfr_w), .literal_out(lit_o), .prog_addr_out(paddr_o),
        .table_mode_out(tmode_o), .operand_pending_out(pend_w));

    // Clock and random fetch stalls
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) stall <= rnd_on && ($random(seed) % 3 == 0);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("FAIL %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Class index of an opcode
    function automatic integer cls(input logic [7:0] op);
        if (op == 8'h02 || op == 8'h04 || op == 8'h08) cls = 1;
        else if (op == 8'h01) cls = 2;
        else if (op == 8'h06 || op == 8'h07) cls = 3;
        else if (op == 8'h37) cls = 4;
        else if (op >= 8'h30 && op <= 8'h36) cls = 5;
        else if (op >= 8'h20 && op <= 8'h2F) cls = 6;
        else if (op >= 8'h40 && op <= 8'h5F) cls = 7;
        else if (op >= 8'h60 && op <= 8'h6F) cls = 8;
        else if (op >= 8'hB0 && op <= 8'hB3) cls = 9;
        else if (op >= 8'hB4 && op <= 8'hB7) cls = 10;
        else if (op >= 8'hA0 && op <= 8'hA5) cls = 11;
        else if (op == 8'hA6 || op == 8'hA7) cls = 12;
        else if (op == 8'hBA || op == 8'hBB) cls = 13;
        else cls = 0;
    endfunction

    // Field checks
    task automatic fields;
        chk(op_o, e_w[23:16]);
        chk(cls_o, 1 << e_k);
        chk(two_w, e_k == 1);
        chk(flg_o, (e_k inside {7, 9, 10}) ? 5'h1F : (e_k == 8) ? 5'h05 : 5'h00);
        if (e_k inside {2, 3, 4, 13}) chk(cyc_o, e_c);
        else chk(cyc_o, e_c);
        case (e_k)
            1: begin
                chk(paddr_o, {e_w2[6:0], e_w[15:0]});
                chk(lit_o, e_w2[15:0]);
            end
            6: begin
                chk(lit_o, {4'h0, e_w[15:4]});
                chk(dst_o, e_w[3:0]);
            end
            7, 8: chk({base_o, smode_o, src_o, dmode_o, dst_o}, e_w[15:0]);
            9: begin
                chk(base_o, e_w[15:12]);
                chk(lit_o, {11'h000, e_w[11:7]});
                if (e_w[6]) chk({dst_o, dmode_o}, {e_w[15:12], 2'h0});
            end
            10: chk({faddr_o, work_reg_zero_w}, {e_w[12:0], e_w[13]});
            11, 12: chk({bpos_o, bfr_w, base_o}, {e_w[11] ? 4'h0 : e_w[15:12], e_w[11:7]});
            13: chk(tmode_o, e_w[15:14]);
            default: ;
        endcase
    endtask

    // Compare, then predict the next taken word
    always @(negedge clk_in) begin
        if (e_on) begin
            chk(dec_v, e_dec);
            chk(nop_v, e_nop);
            chk(pend_w, pend);
            chk(ready_w, 1);
            if (e_dec) fields;
        end
        e_on = 1'b1;
        e_dec = 1'b0;
        e_nop = 1'b0;
        if (!nrst_in) begin
            pend = 1'b0;
            sq = 0;
        end else if (valid_w && pend) begin
            pend = 1'b0;
            e_dec = 1'b1;
            {e_k, e_c, e_w, e_w2} = {32'd1, 32'd2, w1, word_w};
        end else if (valid_w && sq > 0) begin
            sq = sq - 1;
            e_nop = 1'b1;
        end else if (valid_w) begin
            e_k = cls(word_w[23:16]);
            e_w = word_w;
            e_c = (e_k inside {2, 4, 13} || e_k == 5 && cond_w) ? 2 : (e_k == 3) ? 3 : 1;
            if (e_k == 12 && cond_w) e_c = (cls(next_w[23:16]) == 1) ? 3 : 2;
            pend = (e_k == 1);
            w1 = word_w;
            e_nop = (e_k == 0);
            e_dec = (e_k > 1);
            sq = e_c - 1;
        end
    end

    task automatic drain;
        integer n;
        n = 0;
        while (u_iwd_fetch_model.q.size() > 0 && n < 5000) begin
            @(negedge clk_in);
            n = n + 1;
        end
        if (n == 5000) begin
            miscompares = miscompares + 1;
            conclude;
        end
        repeat (4) @(negedge clk_in);
    endtask

    // Directed words, mid-run reset, random words
    initial begin : main
        integer i;
        logic [7:0] op;
        logic [15:0] v;
        logic c;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(negedge clk_in);
        for (i = 0; i < 41; i = i + 1) u_iwd_fetch_model.push(dir[i]);
        drain;
        u_iwd_fetch_model.push(25'h0041111);
        drain;
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(negedge clk_in);
        u_iwd_fetch_model.push(25'h0002222);
        drain;
        rnd_on = 1'b1;
        for (i = 0; i < 400; i = i + 1) begin
            op = ops[$unsigned($random(seed)) % 27];
            v = $random(seed);
            c = $random(seed);
            u_iwd_fetch_model.push({c, op, v});
            v = $random(seed);
            if (cls(op) == 1) u_iwd_fetch_model.push({1'b0, 8'h00, v});
        end
        drain;
        conclude;
    end
endmodule // iwd_decoder_tb

bind iwd_decoder iwd_decoder_checker u_iwd_decoder_checker (.clk_in, .nrst_in, .word_in,
    .word_valid_in, .next_word_in, .cond_true_in, .word_ready_out, .dec_valid_out, .nop_out,
    .opcode_out, .two_word_out, .cycles_out, .flag_mask_out, .operand_pending_out);
`default_nettype wire
